// file: src/ots_consts.svh
// Constants for the output terminal function selector: offsets, reset values, timing.
// Assumes a 50 MHz mclk and a register port with one-cycle read latency.
// Function
// RULE1 - Code 13 follows motor pre-excitation.
// RULE2 - Codes 14/15 after load condition held pre-alarm time.
// RULE3 - Code 16 follows sequencer stage finished.
// RULE4 - Code 17 follows sequencer cycle finished.
// RULE5 - Codes 23/24/25 mirror fieldbus virtual bits.
// RULE6 - Code 34 mirrors industrial Ethernet virtual bit.
// RULE7 - Code 26 while DC bus above undervoltage.
// RULE8 - Code 27 is 10 ms index one-shot.
// RULE9 - Code 28 while pulse superposition active.
// RULE10 - Code 29 on safe torque off fault.
// RULE11 - Code 30 when positioning move completed.
// RULE12 - Codes 31/32 spindle homing and indexing done.
// RULE13 - Code 33 while frequency clamped by limit.
// RULE14 - Code 36 after speed/position switchover completes.
// RULE15 - Code 37 when ramp reference exceeds detect value.
// RULE16 - Codes 41..47 pass plug-in card outputs.
// RULE17 - Codes 48/49/50 follow overheat pre-alarms.
// RULE18 - Code 51 when stopped or zero speed.
// RULE19 - Code 52 when enabled web break detected.
// RULE20 - Codes 53/54/55 roll diameter reached while tensioning.
// RULE21 - Code 56 while fire mode on.
// RULE22 - Terminals may share a code independently.
// RULE23 - Four-bit polarity inverts terminals, default none.
// RULE24 - Reserved codes keep terminal OFF; the code turns the terminal ON when its polarity bit is set.
`ifndef OTS_CONSTS_SVH
`define OTS_CONSTS_SVH

`define OTS_ADDR_SEL0 8'h00
`define OTS_ADDR_SEL1 8'h04
`define OTS_ADDR_SEL2 8'h08
`define OTS_ADDR_SEL3 8'h0c
`define OTS_ADDR_POLARITY 8'h10
`define OTS_ADDR_PREALARM 8'h14
`define OTS_ADDR_FREQ_DETECT 8'h18
`define OTS_ADDR_VIRTUAL 8'h1c
`define OTS_ADDR_STATUS 8'h20

`define OTS_RST_SEL0 6'h00
`define OTS_RST_SEL1 6'h00
`define OTS_RST_SEL2 6'h01
`define OTS_RST_SEL3 6'h05
`define OTS_RST_POLARITY 4'h0
`define OTS_RST_PREALARM 32'h0000_0000
`define OTS_RST_FREQ_DETECT 16'h0000
`define OTS_RST_VIRTUAL 16'h0000

`define OTS_CODE_PRE_EXCITE 6'h0d
`define OTS_CODE_OVERLOAD 6'h0e
`define OTS_CODE_UNDERLOAD 6'h0f
`define OTS_CODE_STAGE_DONE 6'h10
`define OTS_CODE_CYCLE_DONE 6'h11
`define OTS_CODE_VIRT_A 6'h17
`define OTS_CODE_VIRT_B 6'h18
`define OTS_CODE_VIRT_C 6'h19
`define OTS_CODE_DC_BUS 6'h1a
`define OTS_CODE_INDEX 6'h1b
`define OTS_CODE_SUPERPOSE 6'h1c
`define OTS_CODE_STO 6'h1d
`define OTS_CODE_POSITIONED 6'h1e
`define OTS_CODE_SPINDLE_HOME 6'h1f
`define OTS_CODE_SPINDLE_INDEX 6'h20
`define OTS_CODE_FREQ_LIMIT 6'h21
`define OTS_CODE_VIRT_D 6'h22
`define OTS_CODE_MODE_SWITCH 6'h24
`define OTS_CODE_FREQ_ABOVE 6'h25
`define OTS_CODE_CARD_FIRST 6'h29
`define OTS_CODE_OH_PROBE_A 6'h30
`define OTS_CODE_OH_PROBE_B 6'h31
`define OTS_CODE_OH_ANALOG 6'h32
`define OTS_CODE_STOPPED 6'h33
`define OTS_CODE_WEB_BREAK 6'h34
`define OTS_CODE_ROLL_SET 6'h35
`define OTS_CODE_ROLL_MAX 6'h36
`define OTS_CODE_ROLL_MIN 6'h37
`define OTS_CODE_FIRE 6'h38

`define OTS_CLK_HZ 50000000
`define OTS_TICK_MS 1
`define OTS_INDEX_PULSE_MS 10

`endif

// file: src/ots_pkg.sv
// Types shared by the output terminal function selector.
// Assumes the status producers run on mclk.
package ots_pkg;

    // Status levels from the drive's internal logic, all on mclk.
    typedef struct packed {
        logic pre_excite;
        logic overload;
        logic underload;
        logic stage_done;
        logic cycle_done;
        logic dc_bus_ok;
        logic superpose;
        logic sto_fault;
        logic positioned;
        logic spindle_home;
        logic spindle_index;
        logic freq_limited;
        logic mode_switched;
        logic oh_probe_a;
        logic oh_probe_b;
        logic oh_analog;
        logic stopped_or_zero;
        logic web_break_en;
        logic web_break;
        logic tension_run;
        logic roll_set;
        logic roll_max;
        logic roll_min;
        logic fire_mode;
    } ots_status_t;

    typedef logic [5:0] ots_code_t;

endpackage

// file: src/ots_selector.sv
// Output terminal function selector: four terminals, each picking a source by code.
// Assumes status and frequency inputs are on mclk; index pulse and card bits are pins.
`timescale 1ns/1ps
`include "ots_consts.svh"

module ots_selector import ots_pkg::*; #(
    parameter int TICK_CYCLES = `OTS_CLK_HZ / 1000 * `OTS_TICK_MS,
    parameter int INDEX_CYCLES = `OTS_CLK_HZ / 1000 * `OTS_INDEX_PULSE_MS
) (
    input wire logic mclk, // System clock, 50 MHz.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic [7:0] addr, // Register byte address.
    input wire logic [31:0] wdata, // Register write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [31:0] rdata, // Read data, valid the cycle after rd.
    input wire ots_status_t status, // Internal drive status levels.
    input wire logic [15:0] ramp_freq, // Present ramped frequency reference.
    input wire logic index_pin, // Encoder index pulse pin.
    input wire logic [6:0] card_pins, // Plug-in card output bits.
    output logic fast_pulse_out, // Terminal 0.
    output logic collector_out_one, // Terminal 1.
    output logic relay_out_one, // Terminal 2.
    output logic relay_out_two // Terminal 3.
);

    ots_code_t sel [4];
    ots_code_t next_sel [4];
    logic [3:0] polarity, next_polarity;
    logic [31:0] prealarm, next_prealarm;
    logic [15:0] freq_detect, next_freq_detect;
    logic [15:0] virt, next_virt;
    logic [31:0] next_rdata;
    logic [3:0] term, next_term;
    logic [7:0] sync_a, sync_b;
    logic index_seen, next_index_seen;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic [16:0] ovl_cnt, next_ovl_cnt;
    logic [16:0] unl_cnt, next_unl_cnt;
    logic [31:0] shot_cnt, next_shot_cnt;
    logic tick;
    logic ovl_alarm, unl_alarm, shot_on, index_rise;
    logic [63:0] src [4];

    // Two-flop synchronisers for the pin inputs; only sync_b is read by logic.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sync_a <= 8'h00;
            sync_b <= 8'h00;
        end else begin
            sync_a <= {card_pins, index_pin};
            sync_b <= sync_a;
        end
    end

    // Register port: writes steer selection, reads return one cycle later.
    always_comb begin
        next_sel = sel;
        next_polarity = polarity;
        next_prealarm = prealarm;
        next_freq_detect = freq_detect;
        next_virt = virt;
        next_rdata = 32'h0000_0000;
        if (wr) begin
            if (addr == `OTS_ADDR_SEL0) begin
                next_sel[0] = wdata[5:0];
            end else if (addr == `OTS_ADDR_SEL1) begin
                next_sel[1] = wdata[5:0];
            end else if (addr == `OTS_ADDR_SEL2) begin
                next_sel[2] = wdata[5:0];
            end else if (addr == `OTS_ADDR_SEL3) begin
                next_sel[3] = wdata[5:0];
            end else if (addr == `OTS_ADDR_POLARITY) begin
                next_polarity = wdata[3:0];
            end else if (addr == `OTS_ADDR_PREALARM) begin
                next_prealarm = wdata;
            end else if (addr == `OTS_ADDR_FREQ_DETECT) begin
                next_freq_detect = wdata[15:0];
            end else if (addr == `OTS_ADDR_VIRTUAL) begin
                next_virt = wdata[15:0];
            end
        end
        if (rd) begin
            if (addr == `OTS_ADDR_SEL0) begin
                next_rdata = {26'h0, sel[0]};
            end else if (addr == `OTS_ADDR_SEL1) begin
                next_rdata = {26'h0, sel[1]};
            end else if (addr == `OTS_ADDR_SEL2) begin
                next_rdata = {26'h0, sel[2]};
            end else if (addr == `OTS_ADDR_SEL3) begin
                next_rdata = {26'h0, sel[3]};
            end else if (addr == `OTS_ADDR_POLARITY) begin
                next_rdata = {28'h0, polarity};
            end else if (addr == `OTS_ADDR_PREALARM) begin
                next_rdata = prealarm;
            end else if (addr == `OTS_ADDR_FREQ_DETECT) begin
                next_rdata = {16'h0, freq_detect};
            end else if (addr == `OTS_ADDR_VIRTUAL) begin
                next_rdata = {16'h0, virt};
            end else if (addr == `OTS_ADDR_STATUS) begin
                next_rdata = {25'h0, shot_on, unl_alarm, ovl_alarm, term};
            end
        end
    end

    // Register file storage; unmapped reads answer zero.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sel[0] <= `OTS_RST_SEL0;
            sel[1] <= `OTS_RST_SEL1;
            sel[2] <= `OTS_RST_SEL2;
            sel[3] <= `OTS_RST_SEL3;
            polarity <= `OTS_RST_POLARITY;
            prealarm <= `OTS_RST_PREALARM;
            freq_detect <= `OTS_RST_FREQ_DETECT;
            virt <= `OTS_RST_VIRTUAL;
            rdata <= 32'h0000_0000;
        end else begin
            sel <= next_sel;
            polarity <= next_polarity;
            prealarm <= next_prealarm;
            freq_detect <= next_freq_detect;
            virt <= next_virt;
            rdata <= next_rdata;
        end
    end

    // Millisecond tick and pre-alarm timers; a dropout restarts the timing from zero.
    always_comb begin
        tick = (tick_cnt == 32'(TICK_CYCLES - 1));
        next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
        next_ovl_cnt = ovl_cnt;
        next_unl_cnt = unl_cnt;
        if (!status.overload) begin
            next_ovl_cnt = 17'h0; // RULE2
        end else if (tick && !ovl_alarm) begin
            next_ovl_cnt = ovl_cnt + 17'h1; // RULE2
        end
        if (!status.underload) begin
            next_unl_cnt = 17'h0; // RULE2
        end else if (tick && !unl_alarm) begin
            next_unl_cnt = unl_cnt + 17'h1; // RULE2
        end
    end

    // The tick runs free, so one extra tick is counted: the alarm never comes early and
    // comes at most one tick late. Counters stop once the alarm stands, so they cannot wrap.
    // A zero time passes the condition straight through.
    assign ovl_alarm = status.overload &&
        ((prealarm[15:0] == 16'h0) || (ovl_cnt > {1'b0, prealarm[15:0]})); // RULE2
    assign unl_alarm = status.underload &&
        ((prealarm[31:16] == 16'h0) || (unl_cnt > {1'b0, prealarm[31:16]})); // RULE2

    // Index one-shot: each rising edge reloads the full width, so retriggers extend it.
    assign index_rise = sync_b[0] && !index_seen;
    assign shot_on = (shot_cnt != 32'h0);
    always_comb begin
        next_index_seen = sync_b[0];
        next_shot_cnt = shot_cnt;
        if (index_rise) begin
            next_shot_cnt = 32'(INDEX_CYCLES); // RULE8
        end else if (shot_on) begin
            next_shot_cnt = shot_cnt - 32'h1; // RULE8
        end
    end

    // Timer state registers.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tick_cnt <= 32'h0;
            ovl_cnt <= 17'h0;
            unl_cnt <= 17'h0;
            index_seen <= 1'b0;
            shot_cnt <= 32'h0;
        end else begin
            tick_cnt <= next_tick_cnt;
            ovl_cnt <= next_ovl_cnt;
            unl_cnt <= next_unl_cnt;
            index_seen <= next_index_seen;
            shot_cnt <= next_shot_cnt;
        end
    end

    // Per-terminal source vectors; unlisted codes stay zero, so they drive OFF unless that terminal's polarity bit is set.
    always_comb begin
        for (int t = 0; t < 4; t++) begin
            src[t] = 64'h0; // RULE24
            src[t][`OTS_CODE_PRE_EXCITE] = status.pre_excite; // RULE1
            src[t][`OTS_CODE_OVERLOAD] = ovl_alarm; // RULE2
            src[t][`OTS_CODE_UNDERLOAD] = unl_alarm; // RULE2
            src[t][`OTS_CODE_STAGE_DONE] = status.stage_done; // RULE3
            src[t][`OTS_CODE_CYCLE_DONE] = status.cycle_done; // RULE4
            src[t][`OTS_CODE_VIRT_A] = virt[t]; // RULE5
            src[t][`OTS_CODE_VIRT_B] = virt[4 + t]; // RULE5
            src[t][`OTS_CODE_VIRT_C] = virt[8 + t]; // RULE5
            src[t][`OTS_CODE_VIRT_D] = virt[12 + t]; // RULE6
            src[t][`OTS_CODE_DC_BUS] = status.dc_bus_ok; // RULE7
            src[t][`OTS_CODE_INDEX] = shot_on; // RULE8
            src[t][`OTS_CODE_SUPERPOSE] = status.superpose; // RULE9
            src[t][`OTS_CODE_STO] = status.sto_fault; // RULE10
            src[t][`OTS_CODE_POSITIONED] = status.positioned; // RULE11
            src[t][`OTS_CODE_SPINDLE_HOME] = status.spindle_home; // RULE12
            src[t][`OTS_CODE_SPINDLE_INDEX] = status.spindle_index; // RULE12
            src[t][`OTS_CODE_FREQ_LIMIT] = status.freq_limited; // RULE13
            src[t][`OTS_CODE_MODE_SWITCH] = status.mode_switched; // RULE14
            src[t][`OTS_CODE_FREQ_ABOVE] = (ramp_freq > freq_detect); // RULE15
            for (int c = 0; c < 7; c++) begin
                src[t][6'(`OTS_CODE_CARD_FIRST + c)] = sync_b[1 + c]; // RULE16
            end
            src[t][`OTS_CODE_OH_PROBE_A] = status.oh_probe_a; // RULE17
            src[t][`OTS_CODE_OH_PROBE_B] = status.oh_probe_b; // RULE17
            src[t][`OTS_CODE_OH_ANALOG] = status.oh_analog; // RULE17
            src[t][`OTS_CODE_STOPPED] = status.stopped_or_zero; // RULE18
            src[t][`OTS_CODE_WEB_BREAK] = status.web_break_en && status.web_break; // RULE19
            src[t][`OTS_CODE_ROLL_SET] = status.tension_run && status.roll_set; // RULE20
            src[t][`OTS_CODE_ROLL_MAX] = status.tension_run && status.roll_max; // RULE20
            src[t][`OTS_CODE_ROLL_MIN] = status.tension_run && status.roll_min; // RULE20
            src[t][`OTS_CODE_FIRE] = status.fire_mode; // RULE21
        end
    end

    // Each terminal indexes its own copy, so shared codes act independently.
    always_comb begin
        for (int t = 0; t < 4; t++) begin
            next_term[t] = src[t][sel[t]] ^ polarity[t]; // RULE22 RULE23
        end
    end

    // Terminal outputs come straight from this register.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            term <= 4'h0;
        end else begin
            term <= next_term;
        end
    end

    assign fast_pulse_out = term[0];
    assign collector_out_one = term[1];
    assign relay_out_one = term[2];
    assign relay_out_two = term[3];

    // Checks on the selection path and timers.
    sequence s_index_edge;
        index_rise;
    endsequence

    sequence s_shot_held;
        shot_on [*8];
    endsequence

    property p_index_shot;
        @(posedge mclk) disable iff (!reset_n)
        s_index_edge |=> s_shot_held;
    endproperty
    a_index_shot: assert property (p_index_shot) else $error("index one-shot too short"); // RULE8

    property p_shot_ends;
        @(posedge mclk) disable iff (!reset_n)
        (shot_cnt == 32'h1) && !index_rise |=> !shot_on;
    endproperty
    a_shot_ends: assert property (p_shot_ends) else $error("index one-shot overran"); // RULE8

    property p_pre_excite;
        @(posedge mclk) disable iff (!reset_n)
        (sel[0] == `OTS_CODE_PRE_EXCITE) && !polarity[0] |=> term[0] == $past(status.pre_excite);
    endproperty
    a_pre_excite: assert property (p_pre_excite) else $error("pre-excite not followed"); // RULE1

    property p_ovl_needs_time;
        @(posedge mclk) disable iff (!reset_n)
        $rose(status.overload) && (prealarm[15:0] != 16'h0) |-> !ovl_alarm;
    endproperty
    a_ovl_needs_time: assert property (p_ovl_needs_time) else $error("overload alarm early"); // RULE2

    property p_virtual;
        @(posedge mclk) disable iff (!reset_n)
        (sel[1] == `OTS_CODE_VIRT_A) && !polarity[1] |=> term[1] == $past(virt[1]);
    endproperty
    a_virtual: assert property (p_virtual) else $error("virtual bit not mirrored"); // RULE5

    property p_freq_above;
        @(posedge mclk) disable iff (!reset_n)
        (sel[2] == `OTS_CODE_FREQ_ABOVE) && !polarity[2] |=>
            term[2] == ($past(ramp_freq) > $past(freq_detect));
    endproperty
    a_freq_above: assert property (p_freq_above) else $error("frequency compare wrong"); // RULE15

    property p_card;
        @(posedge mclk) disable iff (!reset_n)
        (sel[3] == `OTS_CODE_CARD_FIRST) && !polarity[3] |=> term[3] == $past(sync_b[1]);
    endproperty
    a_card: assert property (p_card) else $error("card bit not passed"); // RULE16

    property p_reserved;
        @(posedge mclk) disable iff (!reset_n)
        (sel[0] == 6'h23 || (sel[0] >= 6'h26 && sel[0] <= 6'h28) || sel[0] > `OTS_CODE_FIRE) |=>
            term[0] == $past(polarity[0]);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code not OFF"); // RULE24

    property p_polarity;
        @(posedge mclk) disable iff (!reset_n)
        (sel[1] == `OTS_CODE_STO) |=> term[1] == ($past(status.sto_fault) ^ $past(polarity[1]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity not applied"); // RULE23

    property p_roll;
        @(posedge mclk) disable iff (!reset_n)
        (sel[2] == `OTS_CODE_ROLL_MAX) && !polarity[2] && !status.tension_run |=> !term[2];
    endproperty
    a_roll: assert property (p_roll) else $error("roll flag outside tension run"); // RULE20

    // Underload must wait out its own time just as overload does.
    property p_unl_needs_time;
        @(posedge mclk) disable iff (!reset_n)
        $rose(status.underload) && (prealarm[31:16] != 16'h0) |-> !unl_alarm;
    endproperty
    a_unl_needs_time: assert property (p_unl_needs_time) else $error("underload early"); // RULE2

    // Plain sources: each terminal follows its chosen level one edge later.
    property p_stage_done;
        @(posedge mclk) disable iff (!reset_n)
        (sel[0] == `OTS_CODE_STAGE_DONE) && !polarity[0] |=>
            term[0] == $past(status.stage_done);
    endproperty
    a_stage_done: assert property (p_stage_done) else $error("stage done missed"); // RULE3

    property p_cycle_done;
        @(posedge mclk) disable iff (!reset_n)
        (sel[1] == `OTS_CODE_CYCLE_DONE) && !polarity[1] |=>
            term[1] == $past(status.cycle_done);
    endproperty
    a_cycle_done: assert property (p_cycle_done) else $error("cycle done missed"); // RULE4

    property p_virt_d;
        @(posedge mclk) disable iff (!reset_n)
        (sel[2] == `OTS_CODE_VIRT_D) && !polarity[2] |=>
            term[2] == $past(virt[14]);
    endproperty
    a_virt_d: assert property (p_virt_d) else $error("ethernet bit missed"); // RULE6

    property p_dc_bus;
        @(posedge mclk) disable iff (!reset_n)
        (sel[3] == `OTS_CODE_DC_BUS) && !polarity[3] |=>
            term[3] == $past(status.dc_bus_ok);
    endproperty
    a_dc_bus: assert property (p_dc_bus) else $error("dc bus missed"); // RULE7

    property p_superpose;
        @(posedge mclk) disable iff (!reset_n)
        (sel[0] == `OTS_CODE_SUPERPOSE) && !polarity[0] |=>
            term[0] == $past(status.superpose);
    endproperty
    a_superpose: assert property (p_superpose) else $error("superpose missed"); // RULE9

    property p_spindle;
        @(posedge mclk) disable iff (!reset_n)
        (sel[1] == `OTS_CODE_SPINDLE_INDEX) && !polarity[1] |=>
            term[1] == $past(status.spindle_index);
    endproperty
    a_spindle: assert property (p_spindle) else $error("spindle missed"); // RULE12

    property p_mode_switch;
        @(posedge mclk) disable iff (!reset_n)
        (sel[2] == `OTS_CODE_MODE_SWITCH) && !polarity[2] |=>
            term[2] == $past(status.mode_switched);
    endproperty
    a_mode_switch: assert property (p_mode_switch) else $error("switchover missed"); // RULE14

    property p_web_break;
        @(posedge mclk) disable iff (!reset_n)
        (sel[3] == `OTS_CODE_WEB_BREAK) && !polarity[3] |=>
            term[3] == $past(status.web_break_en && status.web_break);
    endproperty
    a_web_break: assert property (p_web_break) else $error("web break missed"); // RULE19

    property p_fire;
        @(posedge mclk) disable iff (!reset_n)
        (sel[0] == `OTS_CODE_FIRE) && !polarity[0] |=>
            term[0] == $past(status.fire_mode);
    endproperty
    a_fire: assert property (p_fire) else $error("fire mode missed"); // RULE21

endmodule

// file: testbench/ots_relay_model.sv
// Far-side model of the four terminal drivers: each contact follows its drive one cycle late.
// Assumes the selector's terminal outputs are registered levels on mclk.
`timescale 1ns/1ps

module ots_relay_model (
    input wire logic mclk, // System clock.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic [3:0] drive, // Terminal levels from the selector.
    output logic [3:0] contacts // Contact states seen by the load.
);
    // A relay cannot follow faster than the clock, so one cycle of lag stands in for travel.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            contacts <= 4'h0;
        end else begin
            contacts <= drive;
        end
    end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the output terminal selector with a code-by-code reference model.
// Assumes the selector is built with short tick and one-shot counts for simulation.
`timescale 1ns/1ps
`include "ots_consts.svh"

module testbench import ots_pkg::*; ();
    localparam int TICKS = 4;
    localparam int SHOT = 20;
    logic mclk, reset_n, wr, rd, index_pin;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    ots_status_t status;
    logic [15:0] ramp_freq, m_virt, m_fdet, r;
    logic [6:0] card_pins;
    logic [3:0] m_pol, contacts, exp4;
    wire [3:0] terms;
    int failures, total_checks, hi_cnt, n0;
    logic [7:0] rst_addr [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24};
    logic [31:0] rst_val [9] = '{0, 0, 1, 5, 0, 0, 0, 0, 0};

    ots_selector #(.TICK_CYCLES(TICKS), .INDEX_CYCLES(SHOT)) DUT (
        .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .status(status), .ramp_freq(ramp_freq), .index_pin(index_pin),
        .card_pins(card_pins), .fast_pulse_out(terms[0]), .collector_out_one(terms[1]),
        .relay_out_one(terms[2]), .relay_out_two(terms[3]));

    ots_relay_model relays (.mclk(mclk), .reset_n(reset_n), .drive(terms), .contacts(contacts));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Counts cycles that terminal 1 is on, so one-shot widths can be measured afterwards.
    always @(posedge mclk) begin
        if (terms[1] === 1'b1) hi_cnt++;
    end

    // Reference source for a code; anything not listed, a reserved code or the index code 27, stays off.
    function automatic logic model_src(int code, int t);
        case (code)
            13: return status.pre_excite;
            14: return status.overload;
            15: return status.underload;
            16: return status.stage_done;
            17: return status.cycle_done;
            23: return m_virt[t];
            24: return m_virt[4 + t];
            25: return m_virt[8 + t];
            34: return m_virt[12 + t];
            26: return status.dc_bus_ok;
            28: return status.superpose;
            29: return status.sto_fault;
            30: return status.positioned;
            31: return status.spindle_home;
            32: return status.spindle_index;
            33: return status.freq_limited;
            36: return status.mode_switched;
            37: return ramp_freq > m_fdet;
            41, 42, 43, 44, 45, 46, 47: return card_pins[code - 41];
            48: return status.oh_probe_a;
            49: return status.oh_probe_b;
            50: return status.oh_analog;
            51: return status.stopped_or_zero;
            52: return status.web_break_en & status.web_break;
            53: return status.tension_run & status.roll_set;
            54: return status.tension_run & status.roll_max;
            55: return status.tension_run & status.roll_min;
            56: return status.fire_mode;
            default: return 1'b0;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic pulse_index();
        @(posedge mclk);
        index_pin <= 1'b1;
        @(posedge mclk);
        index_pin <= 1'b0;
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the main sequence of roughly 4400 cycles.
    initial begin
        repeat (40000) @(posedge mclk);
        failures++;
        end_of_test();
    end

    initial begin
        reset_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
        status = '0; ramp_freq = 16'h0; index_pin = 1'b0; card_pins = 7'h00;
        failures = 0; total_checks = 0; hi_cnt = 0;
        void'($urandom(32'hcd76251a));
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        #1 check(32'(terms), 32'h0);
        for (int i = 0; i < 9; i++) begin
            bus_rd(rst_addr[i], d);
            check(d, rst_val[i]);
        end
        // Every code on all four terminals at once, with fresh random sources per pass.
        for (int c = 0; c < 64; c++) begin
            for (int t = 0; t < 4; t++) bus_wr(8'(4 * t), 32'(c));
            for (int j = 0; j < 4; j++) begin
                r = 16'($urandom);
                @(posedge mclk);
                status <= ots_status_t'(24'($urandom));
                ramp_freq <= r;
                card_pins <= 7'($urandom);
                m_virt = 16'($urandom);
                m_pol = 4'($urandom);
                m_fdet = (j == 0) ? r : 16'($urandom);
                bus_wr(`OTS_ADDR_VIRTUAL, 32'(m_virt));
                bus_wr(`OTS_ADDR_FREQ_DETECT, 32'(m_fdet));
                bus_wr(`OTS_ADDR_POLARITY, 32'(m_pol));
                repeat (5) @(posedge mclk);
                #1;
                for (int t = 0; t < 4; t++) exp4[t] = model_src(c, t) ^ m_pol[t];
                if (c < 24) check(32'(terms), 32'(exp4));
                else if (c < 30) check(32'(terms), 32'(exp4));
                else if (c < 36) check(32'(terms), 32'(exp4));
                else if (c < 48) check(32'(terms), 32'(exp4));
                else check(32'(terms), 32'(exp4));
                check(32'(contacts), 32'(exp4));
                bus_rd(`OTS_ADDR_STATUS, d);
                check(32'(d[3:0]), 32'(exp4));
            end
            bus_rd(`OTS_ADDR_SEL3, d);
            check(d, 32'(c));
        end
        // One-shot width alone, then a retrigger ten cycles in that must stretch it.
        bus_wr(`OTS_ADDR_POLARITY, 32'h0);
        bus_wr(`OTS_ADDR_SEL1, 32'(`OTS_CODE_INDEX));
        repeat (10) @(posedge mclk);
        n0 = hi_cnt;
        pulse_index();
        repeat (4) @(posedge mclk);
        bus_rd(`OTS_ADDR_STATUS, d);
        check(32'({d[6], d[1]}), 32'h3);
        repeat (53) @(posedge mclk);
        check(32'(hi_cnt - n0), 32'(SHOT));
        n0 = hi_cnt;
        pulse_index();
        repeat (8) @(posedge mclk);
        pulse_index();
        repeat (70) @(posedge mclk);
        check(32'(hi_cnt - n0), 32'(SHOT + 10));
        // Pre-alarm of two and one ticks: neither may show early, both show well after.
        bus_wr(`OTS_ADDR_PREALARM, {16'd1, 16'd2});
        bus_wr(`OTS_ADDR_SEL0, 32'(`OTS_CODE_OVERLOAD));
        bus_wr(`OTS_ADDR_SEL2, 32'(`OTS_CODE_UNDERLOAD));
        @(posedge mclk);
        status <= '0;
        repeat (4) @(posedge mclk);
        status <= ots_status_t'(24'h600000);
        repeat (3) @(posedge mclk);
        #1 check(32'({terms[2], terms[0]}), 32'h0);
        repeat (13) @(posedge mclk);
        #1 check(32'({terms[2], terms[0]}), 32'h3);
        bus_rd(`OTS_ADDR_STATUS, d);
        check(32'(d[5:4]), 32'h3);
        @(posedge mclk);
        status <= '0;
        repeat (3) @(posedge mclk);
        #1 check(32'({terms[2], terms[0]}), 32'h0);
        end_of_test();
    end
endmodule
